//--- sdram_cmd_pkg.sv
// Purpose: Shared types, timings and bank state model for the SDRAM link.
// Assumes: Both ends run core_clk_i at 250 MHz.
// Notes:   The controller end adds a margin to each of its timers.
package sdram_cmd_pkg;

    // ========================================================
    // Geometry and link timing
    localparam int NUM_BANKS      = 8;
    localparam int BANK_W         = 3;
    localparam int CORE_PERIOD_NS = 4;
    localparam int LINK_DIV       = 8;
    localparam int LINK_HALF      = LINK_DIV / 2;
    localparam int DIV_W          = $clog2(LINK_DIV);
    localparam int TMR_W          = 10;

    typedef logic [TMR_W-1:0]  tmr_t;
    typedef logic [BANK_W-1:0] bank_t;
    typedef logic [DIV_W-1:0]  div_t;

    localparam tmr_t TMR_ONE   = tmr_t'(1);
    localparam div_t LAUNCH_PH = div_t'(LINK_HALF - 1);
    localparam div_t LAST_PH   = div_t'(LINK_DIV - 1);

    // ========================================================
    // Device times in ns; values are plain defaults.
    localparam int PER_BANK_REFRESH_TIME_NS        = 60;
    localparam int ALL_BANK_REFRESH_TIME_NS        = 130;
    localparam int MODE_READ_TIME_NS               = 10;
    localparam int MODE_WRITE_TIME_NS              = 10;
    localparam int PRECHARGE_PERIOD_NS             = 18;
    localparam int ACTIVATE_TO_ACCESS_DELAY_NS     = 18;
    localparam int ACTIVATE_TO_ACTIVATE_SPACING_NS = 10;
    localparam int POWER_DOWN_EXIT_TIME_NS         = 8;
    localparam int BURST_TIME_NS                   = 32;
    localparam int RESET_INIT_TIME_NS              = 1000;

    // Least times round up and never fall below one cycle.
    function automatic int to_cyc(int ns);
        int c;
        c = (ns + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int REFPB_CYC = to_cyc(PER_BANK_REFRESH_TIME_NS);
    localparam int REFAB_CYC = to_cyc(ALL_BANK_REFRESH_TIME_NS);
    localparam int MRR_CYC   = to_cyc(MODE_READ_TIME_NS);
    localparam int MRW_CYC   = to_cyc(MODE_WRITE_TIME_NS);
    localparam int PRE_CYC   = to_cyc(PRECHARGE_PERIOD_NS);
    localparam int RCD_CYC   = to_cyc(ACTIVATE_TO_ACCESS_DELAY_NS);
    localparam int RRD_CYC   = to_cyc(ACTIVATE_TO_ACTIVATE_SPACING_NS);
    localparam int PDX_CYC   = to_cyc(POWER_DOWN_EXIT_TIME_NS);
    localparam int BURST_CYC = to_cyc(BURST_TIME_NS);
    localparam int INIT_CYC  = to_cyc(RESET_INIT_TIME_NS);

    // ========================================================
    // Commands and bank states
    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
        CMD_REF_PB, CMD_REF_AB, CMD_MRW, CMD_MRR, CMD_BST
    } cmd_e;

    typedef enum logic [4:0] {
        ST_POWER_ON, ST_RESETTING, ST_IDLE, ST_ACTIVATING, ST_ACTIVE,
        ST_READING, ST_WRITING, ST_READ_AP, ST_WRITE_AP, ST_PRECHARGING,
        ST_PRE_ALL, ST_REFRESH_PB, ST_REFRESH_AB, ST_MRR_IDLE,
        ST_MRR_RESET, ST_MRR_ACTIVE, ST_MR_WRITING
    } bank_state_e;

    typedef struct packed {
        bank_state_e nxt;
        logic        legal;
    } step_s;

    // Link word as sampled by the device end.
    typedef struct packed {
        logic  clk;
        logic  cke;
        cmd_e  cmd;
        bank_t bank;
        logic  ap;
        logic  pall;
        logic  rst;
    } link_s;

    // Whether a command touches bank b.
    function automatic logic is_hit(cmd_e c, logic pall, bank_t bnk,
                                    bank_t b, bank_t last);
        case (c)
            CMD_NOP:             return 1'b0;
            CMD_REF_AB, CMD_MRW: return 1'b1;
            CMD_PRE:             return pall || (bnk == b);
            CMD_BST:             return last == b;
            default:             return bnk == b;
        endcase
    endfunction

    // Legality and next state of one bank for one command.
    function automatic step_s bank_step(bank_state_e st, cmd_e c,
            logic hit, logic ap, logic pall, logic rst,
            logic all_idle, logic strict);
        step_s r;
        r.nxt   = st;
        r.legal = 1'b1;
        if (hit) begin
            case (c)
                CMD_ACT: begin
                    r.legal = (st == ST_IDLE);
                    r.nxt   = ST_ACTIVATING;
                end
                CMD_REF_PB: begin
                    r.legal = (st == ST_IDLE);
                    r.nxt   = ST_REFRESH_PB;
                end
                CMD_REF_AB: begin
                    r.legal = all_idle;
                    r.nxt   = ST_REFRESH_AB;
                end
                CMD_MRW: begin
                    if (rst) begin
                        r.legal = (st == ST_POWER_ON) || all_idle;
                        r.nxt   = ST_RESETTING;
                    end else begin
                        r.legal = all_idle;
                        r.nxt   = ST_MR_WRITING;
                    end
                end
                CMD_RD: begin
                    // Strict mode waits for a write burst to end.
                    r.legal = (st == ST_ACTIVE) || (st == ST_READING) ||
                              (!strict && st == ST_WRITING);
                    r.nxt   = ap ? ST_READ_AP : ST_READING;
                end
                CMD_WR: begin
                    r.legal = (st == ST_ACTIVE) || (st == ST_WRITING) ||
                              (!strict && st == ST_READING);
                    r.nxt   = ap ? ST_WRITE_AP : ST_WRITING;
                end
                CMD_PRE: begin
                    r.legal = (st == ST_IDLE) || (st == ST_ACTIVE) ||
                              (st == ST_READING) ||
                              (st == ST_WRITING);
                    r.nxt   = pall ? ST_PRE_ALL : ST_PRECHARGING;
                end
                CMD_MRR: begin
                    r.legal = (st == ST_IDLE) || (st == ST_ACTIVE) ||
                              (st == ST_RESETTING);
                    r.nxt   = (st == ST_IDLE) ? ST_MRR_IDLE :
                              (st == ST_ACTIVE) ? ST_MRR_ACTIVE :
                              ST_MRR_RESET;
                end
                CMD_BST: begin
                    r.legal = (st == ST_READING) || (st == ST_WRITING);
                    r.nxt   = ST_ACTIVE;
                end
                default: r.legal = 1'b1;
            endcase
        end
        if (!r.legal) begin
            r.nxt = st;
        end
        return r;
    endfunction

    // State a timed bank state falls into when its time runs out.
    function automatic bank_state_e expire(bank_state_e st);
        case (st)
            ST_MRR_RESET:  return ST_RESETTING;
            ST_MRR_ACTIVE: return ST_ACTIVE;
            ST_ACTIVATING: return ST_ACTIVE;
            ST_READING:    return ST_ACTIVE;
            ST_WRITING:    return ST_ACTIVE;
            ST_READ_AP:    return ST_PRECHARGING;
            ST_WRITE_AP:   return ST_PRECHARGING;
            default:       return ST_IDLE;
        endcase
    endfunction

    // Cycles a state lasts; zero means it lasts until a command.
    function automatic tmr_t load_of(bank_state_e st, int margin);
        int c;
        case (st)
            ST_REFRESH_PB:  c = REFPB_CYC;
            ST_REFRESH_AB:  c = REFAB_CYC;
            ST_MRR_IDLE, ST_MRR_RESET, ST_MRR_ACTIVE: c = MRR_CYC;
            ST_MR_WRITING:  c = MRW_CYC;
            ST_PRECHARGING, ST_PRE_ALL: c = PRE_CYC;
            ST_ACTIVATING:  c = RCD_CYC;
            ST_READING, ST_WRITING, ST_READ_AP, ST_WRITE_AP: c = BURST_CYC;
            ST_RESETTING:   c = INIT_CYC;
            default:        c = 0;
        endcase
        return (c == 0) ? '0 : tmr_t'(c + margin);
    endfunction

endpackage

//--- sdram_cmd_if.sv
// Purpose: Command link between controller end and device end.
// Assumes: Controller drives every wire, link_clk included.
// Notes:   Commands change at the falling edge of link_clk.
`timescale 1ns/10ps
interface sdram_cmd_if;
    import sdram_cmd_pkg::*;

    // ========================================================
    // Link wires
    logic  link_clk;
    logic  cke;
    cmd_e  cmd;
    bank_t bank;
    logic  ap;
    logic  pall;
    logic  rst;

    modport ctrl (output link_clk, output cke, output cmd, output bank,
                  output ap, output pall, output rst);
    modport dev  (input link_clk, input cke, input cmd, input bank,
                  input ap, input pall, input rst);
endinterface // sdram_cmd_if

//--- sdram_bank_tracker.sv
// Purpose: Device end; tracks the state of each bank from the link.
// Assumes: Link wires are asynchronous to core_clk_i.
// Notes:   Illegal commands are flagged and change no bank state.
`timescale 1ns/10ps
module sdram_bank_tracker (
    input  wire logic                       core_clk_i,
    input  wire logic                       rstn_i,
    sdram_cmd_if.dev                        link,
    output sdram_cmd_pkg::bank_state_e      bank_state_o [8],
    output logic                            illegal_cmd_o,
    output logic                            cmd_taken_o
);
    import sdram_cmd_pkg::*;

    // ========================================================
    // Synchroniser and edge finder
    link_s       sync1_r;
    link_s       sync2_r;
    logic        clk_prev_r;
    logic        cke_prev_r;
    bank_t       last_r;
    bank_state_e st_r [NUM_BANKS];
    tmr_t        tmr_r [NUM_BANKS];
    logic [NUM_BANKS-1:0] hit_v;
    logic [NUM_BANKS-1:0] legal_v;
    logic [NUM_BANKS-1:0] idle_v;
    logic        rise;
    logic        take;
    logic        all_legal;

    // Every link wire passes two flops; the first feeds only the second.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_r    <= '0;
            sync2_r    <= '0;
            clk_prev_r <= 1'b0;
        end else begin
            sync1_r    <= link_s'{link.link_clk, link.cke, link.cmd,
                                  link.bank, link.ap, link.pall, link.rst};
            sync2_r    <= sync1_r;
            clk_prev_r <= sync2_r.clk;
        end
    end

    // Clock enable is remembered from the previous rising edge.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cke_prev_r <= 1'b0;
        end else if (rise) begin
            cke_prev_r <= sync2_r.cke;
        end
    end

    assign rise      = sync2_r.clk && !clk_prev_r;
    // Commands count only with enable high on both edges.
    assign take      = rise && cke_prev_r && sync2_r.cke &&
                       (sync2_r.cmd != CMD_NOP);
    assign all_legal = &legal_v;

    // ========================================================
    // Per-bank state and timer
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        step_s s;
        assign hit_v[b]  = is_hit(sync2_r.cmd, sync2_r.pall, sync2_r.bank,
                                  bank_t'(b), last_r);
        assign idle_v[b] = (st_r[b] == ST_IDLE);
        always_comb begin
            s = bank_step(st_r[b], sync2_r.cmd, hit_v[b], sync2_r.ap,
                          sync2_r.pall, sync2_r.rst, &idle_v,
                          1'b0);
        end
        assign legal_v[b] = s.legal;

        // A command restarts the timer; an expiry chains to the next state.
        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                st_r[b]  <= ST_POWER_ON;
                tmr_r[b] <= '0;
            end else if (take && all_legal && hit_v[b]) begin
                st_r[b]  <= s.nxt;
                tmr_r[b] <= load_of(s.nxt, 0);
            end else if (tmr_r[b] == TMR_ONE) begin
                st_r[b]  <= expire(st_r[b]);
                tmr_r[b] <= load_of(expire(st_r[b]), 0);
            end else if (tmr_r[b] != '0) begin
                tmr_r[b] <= tmr_r[b] - TMR_ONE;
            end
        end
        assign bank_state_o[b] = st_r[b];
    end

    // The newest read or write names the bank a terminate ends.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_r <= '0;
        end else if (take && all_legal &&
                     (sync2_r.cmd == CMD_RD || sync2_r.cmd == CMD_WR)) begin
            last_r <= sync2_r.bank;
        end
    end

    // One-cycle flags for each registered command.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            illegal_cmd_o <= 1'b0;
            cmd_taken_o   <= 1'b0;
        end else begin
            illegal_cmd_o <= take && !all_legal;
            cmd_taken_o   <= take && all_legal;
        end
    end

endmodule // sdram_bank_tracker

//--- sdram_cmd_issuer.sv
// Purpose: Controller end; issues only commands that its own strict bank mirror finds legal.
// Assumes: Requests come from logic on core_clk_i.
// Notes:   Timers carry one link period of margin over the device.
`timescale 1ns/10ps
module sdram_cmd_issuer (
    input  wire logic                   core_clk_i,
    input  wire logic                   rstn_i,
    sdram_cmd_if.ctrl                   link,
    input  wire logic                   req_valid_i,
    input  wire sdram_cmd_pkg::cmd_e    req_cmd_i,
    input  wire sdram_cmd_pkg::bank_t   req_bank_i,
    input  wire logic                   req_ap_i,
    input  wire logic                   req_all_i,
    input  wire logic                   req_reset_i,
    output logic                        req_ready_o,
    output logic                        init_done_o,
    output logic                        all_idle_o
);
    import sdram_cmd_pkg::*;

    // ========================================================
    // Declarations
    localparam int   MARGIN_CYC = LINK_DIV;
    // Two rising edges with enable high come before the first command.
    localparam tmr_t EXIT_LOAD  = tmr_t'(PDX_CYC + 2 * LINK_DIV);
    localparam tmr_t RRD_LOAD   = tmr_t'(RRD_CYC + MARGIN_CYC);

    div_t        div_r;
    logic        clk_r;
    logic        cke_r;
    cmd_e        cmd_r;
    bank_t       bank_r;
    logic        ap_r;
    logic        pall_r;
    logic        rst_r;
    tmr_t        exit_r;
    tmr_t        rrd_r;
    bank_t       last_r;
    bank_state_e st_r [NUM_BANKS];
    tmr_t        tmr_r [NUM_BANKS];
    logic [NUM_BANKS-1:0] hit_v;
    logic [NUM_BANKS-1:0] legal_v;
    logic [NUM_BANKS-1:0] idle_v;
    logic        launch;
    logic        rrd_ok;
    logic        go;

    // ========================================================
    // Link clock divider
    // The clock is made here, so the device sees it through its own
    // synchroniser; the command changes half a period before it rises.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_r <= '0;
            clk_r <= 1'b0;
        end else begin
            div_r <= (div_r == LAST_PH) ? '0 : div_r + div_t'(1);
            if (div_r == LAST_PH) begin
                clk_r <= 1'b1;
            end else if (div_r == LAUNCH_PH) begin
                clk_r <= 1'b0;
            end
        end
    end

    assign launch = (div_r == LAUNCH_PH);

    // ========================================================
    // Clock enable and exit wait
    // Enable rises at the first launch point and stays high; power
    // down is not used, so the exit wait is paid once after reset.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cke_r <= 1'b0;
        end else if (launch) begin
            cke_r <= 1'b1;
        end
    end

    // Counts the exit time from the enable rising edge.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            exit_r      <= '0;
            init_done_o <= 1'b0;
        end else if (!cke_r) begin
            exit_r      <= EXIT_LOAD;
            init_done_o <= 1'b0;
        end else begin
            if (exit_r != '0) begin
                exit_r <= exit_r - TMR_ONE;
            end
            init_done_o <= (exit_r == '0);
        end
    end

    // ========================================================
    // Bank mirrors
    // Same model as the device end, in strict mode, so that a read is
    // never let in over a running write and the reverse.
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        step_s s;
        assign hit_v[b]  = is_hit(req_cmd_i, req_all_i, req_bank_i,
                                  bank_t'(b), last_r);
        assign idle_v[b] = (st_r[b] == ST_IDLE);
        always_comb begin
            s = bank_step(st_r[b], req_cmd_i, hit_v[b], req_ap_i,
                          req_all_i, req_reset_i, &idle_v,
                          1'b1);
        end
        assign legal_v[b] = s.legal;

        // Timers start at launch, before the device registers the
        // command, and the margin covers that lead.
        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                st_r[b]  <= ST_POWER_ON;
                tmr_r[b] <= '0;
            end else if (go && hit_v[b]) begin
                st_r[b]  <= s.nxt;
                tmr_r[b] <= load_of(s.nxt, MARGIN_CYC);
            end else if (tmr_r[b] == TMR_ONE) begin
                st_r[b]  <= expire(st_r[b]);
                tmr_r[b] <= load_of(expire(st_r[b]), MARGIN_CYC);
            end else if (tmr_r[b] != '0) begin
                tmr_r[b] <= tmr_r[b] - TMR_ONE;
            end
        end
    end

    // ========================================================
    // Activate spacing
    // Applies to any pair of activates, which is stricter than needed
    // for a second activate to the same bank but never too loose.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rrd_r <= '0;
        end else if (go && req_cmd_i == CMD_ACT) begin
            rrd_r <= RRD_LOAD;
        end else if (rrd_r != '0) begin
            rrd_r <= rrd_r - TMR_ONE;
        end
    end

    assign rrd_ok = (req_cmd_i != CMD_ACT) || (rrd_r == '0);

    // ========================================================
    // Issue decision
    // A request is held off, with NOP on the link, until every bank
    // it touches can take it; nothing is ever refused outright.
    assign go = launch && init_done_o && req_valid_i && rrd_ok &&
                (&legal_v);

    // Newest burst bank, so a terminate is checked against it.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_r <= '0;
        end else if (go && (req_cmd_i == CMD_RD ||
                            req_cmd_i == CMD_WR)) begin
            last_r <= req_bank_i;
        end
    end

    // Link command registers change only at the launch point.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_r  <= CMD_NOP;
            bank_r <= '0;
            ap_r   <= 1'b0;
            pall_r <= 1'b0;
            rst_r  <= 1'b0;
        end else if (launch) begin
            cmd_r  <= go ? req_cmd_i : CMD_NOP;
            bank_r <= go ? req_bank_i : '0;
            ap_r   <= go && req_ap_i;
            pall_r <= go && req_all_i;
            rst_r  <= go && req_reset_i;
        end
    end

    // Taken pulse and idle summary for the requester.
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_ready_o <= 1'b0;
            all_idle_o  <= 1'b0;
        end else begin
            req_ready_o <= go;
            all_idle_o  <= &idle_v;
        end
    end

    // ========================================================
    // Link drive
    assign link.link_clk = clk_r;
    assign link.cke      = cke_r;
    assign link.cmd      = cmd_r;
    assign link.bank     = bank_r;
    assign link.ap       = ap_r;
    assign link.pall     = pall_r;
    assign link.rst      = rst_r;

endmodule // sdram_cmd_issuer

//--- sdram_link_chk.sv
// Purpose: Assertions on the link between the two ends.
// Assumes: One command launch per 8 core cycles.
// Notes:   Each window opens at a launch, as link_clk falls.
`timescale 1ns/10ps
module sdram_link_chk (
    input wire logic                  core_clk_i,
    input wire logic                  rstn_i,
    input wire logic                  link_clk,
    input wire logic                  cke,
    input wire sdram_cmd_pkg::cmd_e   cmd,
    input wire sdram_cmd_pkg::bank_t  bank,
    input wire logic                  ap,
    input wire logic                  pall,
    input wire logic                  rst
);
    import sdram_cmd_pkg::*;
    // ====================
    // A launch of command c, and one quiet link period.
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_go(cmd_e c);
        $fell(link_clk) && cmd == c;
    endsequence
    sequence s_nop;
        (cmd == CMD_NOP) [*8];
    endsequence
    // The next launch after a timed command must respect its window.
    a_cke_stays: assert property (cke |=> cke)
        else $error("cke dropped");
    a_refab_quiet: assert property (s_go(CMD_REF_AB) |->
        ##8 s_nop ##1 s_nop ##1 s_nop ##1 s_nop) else $error("refab hit");
    a_refpb_bank: assert property (s_go(CMD_REF_PB) |-> ##8
        (cmd == CMD_NOP || bank != $past(bank, 8)) [*8]) else $error("pb");
    a_reset_quiet: assert property (s_go(CMD_MRW) ##0 rst |->
        ##8 (cmd inside {CMD_NOP, CMD_MRR}) [*8]) else $error("reset hit");
    a_act_space: assert property (s_go(CMD_ACT) |->
        ##8 cmd != CMD_ACT) else $error("activates too close");
    a_preall_quiet: assert property (s_go(CMD_PRE) ##0 pall |->
        ##8 s_nop) else $error("precharge all hit");
    a_rd_then_wr: assert property (s_go(CMD_RD) ##0 !ap |-> ##8
        !(cmd == CMD_WR && bank == $past(bank, 8))) else $error("rd wr");
    a_wr_then_rd: assert property (s_go(CMD_WR) ##0 !ap |-> ##8
        !(cmd == CMD_RD && bank == $past(bank, 8))) else $error("wr rd");
    a_ap_quiet: assert property (s_go(CMD_RD) ##0 ap |-> ##8
        cmd == CMD_NOP || bank != $past(bank, 8)) else $error("ap hit");
endmodule // sdram_link_chk

//--- testbench.sv
// Purpose: Sends requests and checks the tracked bank states.
// Assumes: The issuer holds each request until it is legal.
// Notes:   Expected states wait in a queue until taken.
`timescale 1ns/10ps
module testbench;
    import sdram_cmd_pkg::*;
    logic        core_clk_i = 0, rstn_i = 0, rdy, taken, bad, idle, done;
    logic [10:0] rq = '0;
    bank_state_e st [8], qs [$];
    int          n_mismatch = 0, samples_checked = 0, cyc = 0;
    int          qb [$], r1, r2;
    sdram_cmd_if lnk ();
    sdram_cmd_issuer sdram_cmd_issuer_i (.core_clk_i, .rstn_i, .link(lnk),
        .req_valid_i(rq[10]), .req_cmd_i(cmd_e'(rq[9:6])),
        .req_bank_i(rq[5:3]), .req_ap_i(rq[2]), .req_all_i(rq[1]),
        .req_reset_i(rq[0]), .req_ready_o(rdy), .init_done_o(done),
        .all_idle_o(idle));
    sdram_bank_tracker sdram_bank_tracker_i (.core_clk_i, .rstn_i,
        .link(lnk), .bank_state_o(st), .illegal_cmd_o(bad),
        .cmd_taken_o(taken));
    sdram_link_chk sdram_link_chk_i (.core_clk_i, .rstn_i,
        .link_clk(lnk.link_clk), .cke(lnk.cke), .cmd(lnk.cmd),
        .bank(lnk.bank), .ap(lnk.ap), .pall(lnk.pall), .rst(lnk.rst));
    always #2 core_clk_i = ~core_clk_i;
    task automatic complete_run;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_st(bank_state_e g, bank_state_e e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t state %0d not %0d", $time, g, e);
        end
    endtask
    task automatic chk_b(logic g, logic e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t flag %b not %b", $time, g, e);
        end
    endtask
    // Hold a request until it is launched; queue the state it must give.
    task automatic send(cmd_e c, int b, logic a, logic p, logic r,
                        bank_state_e e);
        @(posedge core_clk_i);
        rq <= {1'b1, c, bank_t'(b), a, p, r};
        do @(posedge core_clk_i); while (rdy !== 1'b1);
        rq[10] <= 1'b0;
        qb.push_back(b);
        qs.push_back(e);
        chk_b(lnk.cke, 1'b1);
        chk_b(done, 1'b1);
    endtask
    // Every taken command is compared with the queued expectation.
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 6000) begin
            n_mismatch++;
            $display("ERROR %0t timeout", $time);
            complete_run();
        end else begin
            if (rstn_i)
                chk_b(bad, 1'b0);
            if (taken === 1'b1) begin
                chk_st(st[qb.pop_front()], qs.pop_front());
            end
        end
    end
    initial begin
        void'($urandom(32'h5B22));
        r1 = $urandom_range(7);
        r2 = (r1 + 1 + $urandom_range(6)) % 8;
        repeat (5) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        send(CMD_MRW, 0, 0, 0, 1, ST_RESETTING);
        send(CMD_MRR, r1, 0, 0, 0, ST_MRR_RESET);
        send(CMD_REF_AB, 0, 0, 0, 0, ST_REFRESH_AB);
        send(CMD_REF_PB, r1, 0, 0, 0, ST_REFRESH_PB);
        send(CMD_MRW, 0, 0, 0, 0, ST_MR_WRITING);
        send(CMD_MRR, r2, 0, 0, 0, ST_MRR_IDLE);
        send(CMD_PRE, r1, 0, 0, 0, ST_PRECHARGING);
        send(CMD_ACT, r1, 0, 0, 0, ST_ACTIVATING);
        send(CMD_ACT, r2, 0, 0, 0, ST_ACTIVATING);
        send(CMD_MRR, r2, 0, 0, 0, ST_MRR_ACTIVE);
        send(CMD_RD, r1, 0, 0, 0, ST_READING);
        send(CMD_WR, r1, 0, 0, 0, ST_WRITING);
        send(CMD_RD, r1, 0, 0, 0, ST_READING);
        send(CMD_WR, r2, 0, 0, 0, ST_WRITING);
        send(CMD_BST, r2, 0, 0, 0, ST_ACTIVE);
        send(CMD_RD, r1, 1, 0, 0, ST_READ_AP);
        send(CMD_PRE, 0, 0, 1, 0, ST_PRE_ALL);
        chk_b(idle, 1'b0);
        repeat (2) @(posedge core_clk_i);
        while (idle !== 1'b1) @(posedge core_clk_i);
        chk_b(qs.size() == 0, 1'b1);
        for (int b = 0; b < 8; b++)
            chk_st(st[b], ST_IDLE);
        complete_run();
    end
endmodule // testbench
